// ==== useq_defines.vh ====
// constants for the microprogram sequencer
`ifndef USEQ_DEFINES_VH
`define USEQ_DEFINES_VH
`define ADDR_W 9
`define ROW_W 5
`define COL_W 4
`define ROW_LSB 4
`define ROW_MSB 8
`define COL_MSB 3
`define FSEL_SET_BOTH 2'h0
`define FSEL_SET_ZERO 2'h1
`define FSEL_SET_CARRY 2'h2
`define FSEL_HOLD 2'h3
`define FOUT_ZERO 2'h0
`define FOUT_CARRY 2'h1
`define FOUT_ZFLAG 2'h2
`define FOUT_ONE 2'h3
`define COL_IRQ 4'hf
`define FN_COL_KEEP 2'h0
`define FN_ROW_ZERO 3'h2
`define FN_ROW_KEEP 3'h3
`define FN_COL_CODE 4'h8
`define FN_CARRY_TEST 4'ha
`define FN_ZERO_TEST 4'hb
`define FN_LATCH_ALL 4'hc
`define FN_LATCH_HI 4'hd
`define FN_GROUP_EN 4'he
`define FN_BUS_TEST 5'h1e
`define FN_LATCH_LO 5'h1f
`define ROW_ZERO 5'h00
`define COL_TEST_MID 2'h1
`define COL_LO_TOP 2'h3
`define ADDR_RST 9'h000
`define LATCH_RST 4'h0
`endif

// ==== useq_flags.v ====
// carry/zero flag pair with load select and output mux
`timescale 1ns/1ps
`default_nettype none
`include "useq_defines.vh"
module useq_flags (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire f_latch,
  input wire [1:0] fin_sel,
  input wire [1:0] fout_sel,
  output wire carry,
  output wire zero,
  output reg flag_out_line
);
  reg carry_reg;
  reg zero_reg;
  // reset only gives a defined start; software must not rely on it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (ce) begin
      case (fin_sel)
        `FSEL_SET_BOTH: begin
          carry_reg <= f_latch;
          zero_reg <= f_latch;
        end
        `FSEL_SET_ZERO: zero_reg <= f_latch;
        `FSEL_SET_CARRY: carry_reg <= f_latch;
        default: begin
        end
      endcase
    end
  end
  assign carry = carry_reg;
  assign zero = zero_reg;
  always @* begin
    case (fout_sel)
      `FOUT_ZERO: flag_out_line = 1'b0;
      `FOUT_CARRY: flag_out_line = carry_reg;
      `FOUT_ZFLAG: flag_out_line = zero_reg;
      default: flag_out_line = 1'b1;
    endcase
  end
endmodule // useq_flags
`default_nettype wire

// ==== useq_top.v ====
// microprogram sequencer: next-address logic, test latch and flags
`timescale 1ns/1ps
`default_nettype none
`include "useq_defines.vh"
module useq_top (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire [6:0] next_addr_func_code,
  input wire [3:0] primary_instr_bus_n,
  input wire [3:0] secondary_instr_bus_n,
  input wire [3:0] flag_select_lines,
  input wire flag_in_line,
  input wire load_strobe,
  output wire [8:0] uaddr,
  output wire [3:0] held_test_latch,
  output wire latch_out_en,
  output wire flag_out_line,
  output wire irq_strobe_en
);
  // every input except clk, arst_n and ce is a microinstruction field or array flag on this clock
  reg [`ADDR_W-1:0] uaddr_reg;
  reg [`ADDR_W-1:0] uaddr_next;
  reg [`COL_W-1:0] latch_reg;
  reg [`COL_W-1:0] latch_next;
  wire [6:0] ac;
  wire [`ROW_W-1:0] row;
  wire [`COL_W-1:0] col;
  wire [`COL_W-1:0] px;
  wire [`COL_W-1:0] sx;
  wire carry;
  wire zero;
  wire fn_col_keep;
  wire fn_row_zero;
  wire fn_row_keep;
  wire fn_col_code;
  wire fn_carry_test;
  wire fn_zero_test;
  wire fn_latch_all;
  wire fn_latch_hi;
  wire fn_group_en;
  wire fn_bus_test;
  wire fn_latch_lo;
  wire [`ADDR_W-1:0] nxt_col_keep;
  wire [`ADDR_W-1:0] nxt_row_zero;
  wire [`ADDR_W-1:0] nxt_row_keep;
  wire [`ADDR_W-1:0] nxt_carry;
  wire [`ADDR_W-1:0] nxt_zero;
  wire [`ADDR_W-1:0] nxt_latch_all;
  wire [`ADDR_W-1:0] nxt_latch_hi;
  wire [`ADDR_W-1:0] nxt_group;
  wire [`ADDR_W-1:0] nxt_bus;
  wire [`ADDR_W-1:0] nxt_latch_lo;
  assign ac = next_addr_func_code;
  assign row = uaddr_reg[`ROW_MSB:`ROW_LSB];
  assign col = uaddr_reg[`COL_MSB:0];
  // buses are active low at the pins; invert once here
  genvar i;
  generate
    for (i = 0; i < `COL_W; i = i + 1) begin : g_bus_inv
      assign px[i] = ~primary_instr_bus_n[i];
      assign sx[i] = ~secondary_instr_bus_n[i];
    end
  endgenerate
  // function decode; prefixes differ in length
  assign fn_col_keep = (ac[6:5] == `FN_COL_KEEP);
  assign fn_row_zero = (ac[6:4] == `FN_ROW_ZERO);
  assign fn_row_keep = (ac[6:4] == `FN_ROW_KEEP);
  assign fn_col_code = (ac[6:3] == `FN_COL_CODE);
  assign fn_carry_test = (ac[6:3] == `FN_CARRY_TEST);
  assign fn_zero_test = (ac[6:3] == `FN_ZERO_TEST);
  assign fn_latch_all = (ac[6:3] == `FN_LATCH_ALL);
  assign fn_latch_hi = (ac[6:3] == `FN_LATCH_HI);
  assign fn_group_en = (ac[6:3] == `FN_GROUP_EN);
  assign fn_bus_test = (ac[6:2] == `FN_BUS_TEST);
  assign fn_latch_lo = (ac[6:2] == `FN_LATCH_LO);
  // candidate next addresses, one per function except fn_col_code, which shares nxt_row_keep
  assign nxt_col_keep = {ac[4:0], col};
  assign nxt_row_zero = {`ROW_ZERO, ac[3:0]};
  assign nxt_row_keep = {row, ac[3:0]};
  assign nxt_carry = {row, col[3], `COL_TEST_MID, carry};
  assign nxt_zero = {row, col[3], `COL_TEST_MID, zero};
  assign nxt_latch_all = {row, 1'b1, latch_reg[3:1]};
  assign nxt_latch_hi = {row, `COL_TEST_MID, latch_reg[3:2]};
  assign nxt_group = {row[4:3], ac[2:0], col};
  assign nxt_bus = {row[4:2], ac[1:0], px};
  assign nxt_latch_lo = {row[4:3], 1'b1, ac[1:0], `COL_LO_TOP, latch_reg[1:0]};
  // unlisted codes hold the address rather than jump somewhere odd
  always @* begin
    uaddr_next = uaddr_reg;
    if (load_strobe) begin
      uaddr_next = {1'b0, sx, px};
    end else if (fn_col_keep) begin
      uaddr_next = nxt_col_keep;
    end else if (fn_row_zero) begin
      uaddr_next = nxt_row_zero;
    end else if (fn_row_keep || fn_col_code) begin
      uaddr_next = nxt_row_keep;
    end else if (fn_carry_test) begin
      uaddr_next = nxt_carry;
    end else if (fn_zero_test) begin
      uaddr_next = nxt_zero;
    end else if (fn_latch_all) begin
      uaddr_next = nxt_latch_all;
    end else if (fn_latch_hi) begin
      uaddr_next = nxt_latch_hi;
    end else if (fn_group_en) begin
      uaddr_next = nxt_group;
    end else if (fn_bus_test) begin
      uaddr_next = nxt_bus;
    end else if (fn_latch_lo) begin
      uaddr_next = nxt_latch_lo;
    end
  end
  // capture happens even under load: load only overrides the address
  always @* begin
    latch_next = latch_reg;
    if (fn_bus_test) begin
      latch_next = sx;
    end
  end
  // reset value only for determinism; firmware must load or jump first
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uaddr_reg <= `ADDR_RST;
      latch_reg <= `LATCH_RST;
    end else if (ce) begin
      uaddr_reg <= uaddr_next;
      latch_reg <= latch_next;
    end
  end
  // flag input sampled when clock is low, modelled as registered-edge load
  useq_flags u_flags (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .f_latch(flag_in_line),
    .fin_sel(flag_select_lines[1:0]),
    .fout_sel(flag_select_lines[3:2]),
    .carry(carry),
    .zero(zero),
    .flag_out_line(flag_out_line)
  );
  assign uaddr = uaddr_reg;
  assign held_test_latch = latch_reg;
  assign latch_out_en = fn_group_en;
  assign irq_strobe_en = fn_row_zero && (ac[3:0] == `COL_IRQ);
endmodule // useq_top
`default_nettype wire

// ==== useq_bus_model.sv ====
// active-low instruction bus drivers
`timescale 1ns/1ps
`default_nettype none
module useq_bus_model (
  input wire logic [7:0] ps,
  output logic [7:0] ps_n
);
  assign ps_n = ~ps;
endmodule // useq_bus_model
`default_nettype wire

// ==== useq_top_assertions.sv ====
// port checks for useq_top
`timescale 1ns/1ps
`default_nettype none
module useq_top_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic load_strobe,
  input wire logic flag_out_line,
  input wire logic irq_strobe_en,
  input wire logic latch_out_en,
  input wire logic [6:0] next_addr_func_code,
  input wire logic [3:0] primary_instr_bus_n,
  input wire logic [3:0] secondary_instr_bus_n,
  input wire logic [3:0] held_test_latch,
  input wire logic [3:0] flag_select_lines,
  input wire logic [8:0] uaddr
);
  wire [6:0] a = next_addr_func_code;
  wire [8:0] u = uaddr;
  wire [7:0] b = ~{secondary_instr_bus_n, primary_instr_bus_n};
  wire [1:0] o = flag_select_lines[3:2];
  wire go = ce & ~load_strobe;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence jmp(p); go && p; endsequence
  row_load_a: assert property (jmp(a[6:5]==2'h0) |=> u=={$past(a[4:0]),$past(u[3:0])})
    else $error("row jump");
  zero_row_a: assert property (jmp(a[6:4]==3'h2) |=> u=={5'h0,$past(a[3:0])})
    else $error("zero row");
  cur_row_a: assert property (jmp(a[6:4]==3'h3) |=> u=={$past(u[8:4]),$past(a[3:0])})
    else $error("row keep");
  latch_col_a: assert property (jmp(a[6:3]==4'hc) |=> u[3:0]=={1'b1,$past(held_test_latch[3:1])})
    else $error("latch column");
  load_addr_a: assert property (ce && load_strobe |=> u=={1'b0,$past(b)})
    else $error("load");
  latch_cap_a: assert property (ce && a[6:2]==5'h1e |=> held_test_latch==$past(b[7:4]))
    else $error("latch capture");
  irq_en_a: assert property (irq_strobe_en==(a==7'h2f))
    else $error("strobe enable");
  flag_out_a: assert property (o[1]==o[0] |-> flag_out_line==o[1])
    else $error("flag out");
  latch_hi_a: assert property (jmp(a[6:3]==4'hd) |=> u=={$past(u[8:4]),2'h1,$past(held_test_latch[3:2])})
    else $error("latch high pair");
  latch_lo_a: assert property (jmp(a[6:2]==5'h1f) |=> u=={$past(u[8:7]),1'b1,$past(a[1:0]),2'h3,$past(held_test_latch[1:0])})
    else $error("latch low pair");
  bus_jump_a: assert property (jmp(a[6:2]==5'h1e) |=> u=={$past(u[8:6]),$past(a[1:0]),$past(b[3:0])})
    else $error("bus jump");
  group_en_a: assert property (latch_out_en==(a[6:3]==4'he))
    else $error("latch enable");
  ce_freeze_a: assert property (!ce |=> $stable(u) && $stable(held_test_latch))
    else $error("freeze");
endmodule // useq_top_assertions
bind useq_top useq_top_assertions u_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
  .load_strobe(load_strobe), .flag_out_line(flag_out_line), .irq_strobe_en(irq_strobe_en),
  .latch_out_en(latch_out_en), .next_addr_func_code(next_addr_func_code),
  .primary_instr_bus_n(primary_instr_bus_n), .secondary_instr_bus_n(secondary_instr_bus_n),
  .held_test_latch(held_test_latch), .flag_select_lines(flag_select_lines), .uaddr(uaddr));
`default_nettype wire

// ==== useq_top_bench.sv ====
// bench for useq_top
`timescale 1ns/1ps
`default_nettype none
module useq_top_bench;
  logic clk = 0, arst_n = 0, ce = 1, load_strobe = 0, flag_in_line = 0;
  logic [6:0] next_addr_func_code = 7'h00;
  logic [3:0] flag_select_lines = 4'hf;
  logic [7:0] ps = 8'h00;
  wire [3:0] primary_instr_bus_n, secondary_instr_bus_n, held_test_latch;
  wire [8:0] uaddr;
  wire latch_out_en, flag_out_line, irq_strobe_en;
  int mismatches = 0, tests_run = 0;
  always #50 clk = ~clk;
  useq_bus_model u_bus (.ps(ps), .ps_n({primary_instr_bus_n, secondary_instr_bus_n}));
  useq_top u_dut (.*);
  task chk(input logic [8:0] s, e);
    tests_run++;
    if (s !== e) begin mismatches++; $display("MISMATCH %0t %h %h", $time, s, e); end
  endtask
  task step(input logic [6:0] c, input logic [3:0] f, input logic i);
    @(negedge clk) {next_addr_func_code, flag_select_lines, flag_in_line} = {c, f, i};
    @(posedge clk) #1;
  endtask
  task t_load;
    @(negedge clk) {ps, load_strobe} = 9'h0b9;
    step(7'h79, 4'hf, 0); chk(uaddr, 9'h0c5);
    @(negedge clk) load_strobe = 0;
  endtask
  task t_jump;
    step(7'h13, 4'hf, 0); chk(uaddr, 9'h135);
    step(7'h2f, 4'hf, 0); chk(irq_strobe_en, 1'b1);
    step(7'h30, 4'h4, 1); chk(flag_out_line, 1'b1);
    step(7'h50, 4'h9, 0); chk(uaddr, 9'h003);
    step(7'h58, 4'h7, 0); chk(uaddr, 9'h002);
  endtask
  // latch tests read what the bus test captured one to three cycles before
  task t_latch;
    @(negedge clk) ps = 8'h69;
    step(7'h79, 4'hf, 0); chk(uaddr, 9'h016);
    step(7'h60, 4'hf, 0); chk(uaddr, 9'h01c);
    step(7'h68, 4'hf, 0); chk(uaddr, 9'h016);
    step(7'h7e, 4'hf, 0); chk(uaddr, 9'h06d);
  endtask
  // flag out codes, group enable, clock-enable freeze and a mid-run reset
  task t_misc;
    step(7'h35, 4'hf, 0); chk(uaddr, 9'h065);
    chk(flag_out_line, 1'b1);
    step(7'h2a, 4'hb, 0); chk(uaddr, 9'h00a);
    chk(irq_strobe_en, 1'b0);
    chk(flag_out_line, 1'b0);
    step(7'h33, 4'h3, 0); chk(flag_out_line, 1'b0);
    step(7'h31, 4'h7, 0); chk(flag_out_line, 1'b1);
    step(7'h75, 4'hf, 0); chk(uaddr, 9'h051);
    chk(latch_out_en, 1'b1);
    chk(held_test_latch, 4'h9);
    @(negedge clk) ce = 0;
    step(7'h2f, 4'h8, 1); chk(uaddr, 9'h051);
    chk(flag_out_line, 1'b0);
    @(negedge clk) ce = 1;
    step(7'h3c, 4'h8, 1); chk(uaddr, 9'h00c);
    chk(flag_out_line, 1'b1);
    @(negedge clk) arst_n = 0;
    #1 chk(uaddr, 9'h000);
    chk(held_test_latch, 4'h0);
    repeat (2) @(negedge clk);
    arst_n = 1;
    step(7'h21, 4'hf, 0); chk(uaddr, 9'h001);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) arst_n = 1;
    t_load;
    t_jump;
    t_latch;
    t_misc;
    print_verdict;
  end
  initial begin
    #20000;
    mismatches++;
    print_verdict;
  end
endmodule // useq_top_bench
`default_nettype wire
